// *** rtl/hwy_pkg.sv ***
// Package: register map, field layout and carrier types for the highway block
package hwy_pkg;
  // Register offsets
  localparam logic [7:0] OFS_MODE = 8'h21;
  localparam logic [7:0] OFS_TXS_LO = 8'h22;
  localparam logic [7:0] OFS_TXS_HI = 8'h23;
  localparam logic [7:0] OFS_RXS_LO = 8'h24;
  localparam logic [7:0] OFS_RXS_HI = 8'h25;
  localparam logic [7:0] OFS_GAIN = 8'h26;
  // Extra status register holding the last received sample, low and high byte
  localparam logic [7:0] OFS_RXD_LO = 8'h27;
  localparam logic [7:0] OFS_RXD_HI = 8'h28;
  // Field positions in the mode register
  localparam int BIT_LOOP = 7;
  localparam int BIT_EN = 5;
  localparam int BIT_FMT = 3;
  localparam int BIT_CPB = 1;
  localparam int BIT_REL = 0;
  // Field positions in the gain register
  localparam int BIT_DIR = 4;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // Writable masks; reserved bits read as zero
  localparam logic [7:0] MASK_MODE = 8'hbb;
  localparam logic [7:0] MASK_HI = 8'h03;
  localparam logic [7:0] MASK_GAIN = 8'h1f;
  // Gain limits in dB
  localparam logic [3:0] GAIN_MAX_DB = 4'hc;
  // Sample formats
  localparam logic [1:0] FMT_ALAW = 2'h0;
  localparam logic [1:0] FMT_ULAW = 2'h1;
  localparam logic [1:0] FMT_LIN8 = 2'h2;
  localparam logic [1:0] FMT_LIN16 = 2'h3;
  // Sample widths in bits
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
  // Decoded configuration carried to the framing logic
  typedef struct packed {
    logic loopback;
    logic enable;
    logic [1:0] fmt;
    logic two_clk;
    logic rel_fall;
    logic [9:0] tx_start_count;
    logic [9:0] rx_start_count;
  } hwy_cfg_t;
  // Coarse gain setting as applied to the transmit path
  typedef struct packed {
    logic atten;
    logic [3:0] db;
  } gain_t;
endpackage

// *** rtl/sample_fifo.sv ***
// Synchronous valid/ready FIFO for transmit samples
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Storage array
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  // Data write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** rtl/pcm_highway_config.sv ***
// Highway configuration registers, framing engine and coarse transmit gain
`timescale 1ns/1ps
`default_nettype none
module pcm_highway_config import hwy_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Transmit samples from the codec path, 16-bit two's complement; companded formats take the coded byte in the low byte
  input wire logic [15:0] tx_sample,
  input wire logic tx_sample_valid,
  output logic tx_sample_ready,
  // Line-side loopback steering and coarse gain to the analog path
  output logic analog_loopback,
  output logic coarse_tx_direction,
  output logic [3:0] coarse_tx_db,
  // Received sample to the codec path
  output logic [15:0] rx_sample,
  output logic rx_sample_valid,
  // Highway pins
  input wire logic bit_clk,
  input wire logic frame_sync,
  input wire logic hwy_rx,
  output logic hwy_tx,
  output logic hwy_tx_oe
);
  // Register file
  logic [7:0] mode_r, txs_lo_r, txs_hi_r, rxs_lo_r, rxs_hi_r, gain_r;
  logic [15:0] rxd_r;
  logic [7:0] rdata_nxt;
  hwy_cfg_t cfg;
  gain_t gain;

  // Field decode
  assign cfg.loopback = mode_r[BIT_LOOP];
  assign cfg.enable = mode_r[BIT_EN];
  assign cfg.fmt = mode_r[BIT_FMT+:2];
  assign cfg.two_clk = mode_r[BIT_CPB];
  assign cfg.rel_fall = mode_r[BIT_REL];
  assign cfg.tx_start_count = {txs_hi_r[1:0], txs_lo_r};
  assign cfg.rx_start_count = {rxs_hi_r[1:0], rxs_lo_r};

  // Gain mapping: zero is 0 dB either way, gain saturates at 12 dB
  function automatic gain_t map_gain(input logic [7:0] g);
    gain_t r;
    r.atten = g[BIT_DIR];
    if (g[3:0] == 4'h0) begin
      r.db = 4'h0;
    end else if (!g[BIT_DIR] && g[3:2] == 2'h3) begin
      r.db = GAIN_MAX_DB;
    end else begin
      r.db = g[3:0];
    end
    return r;
  endfunction
  assign gain = map_gain(gain_r);

  // Register writes; reserved bits are masked so they read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= RST_REG;
      txs_lo_r <= RST_REG;
      txs_hi_r <= RST_REG;
      rxs_lo_r <= RST_REG;
      rxs_hi_r <= RST_REG;
      gain_r <= RST_REG;
    end else if (reg_wr) begin
      // Bit 2 is not stored; software is expected to write zero there
      if (reg_addr == OFS_MODE) begin
        mode_r <= reg_wdata & MASK_MODE;
      end else if (reg_addr == OFS_TXS_LO) begin
        txs_lo_r <= reg_wdata;
      end else if (reg_addr == OFS_TXS_HI) begin
        txs_hi_r <= reg_wdata & MASK_HI;
      end else if (reg_addr == OFS_RXS_LO) begin
        rxs_lo_r <= reg_wdata;
      end else if (reg_addr == OFS_RXS_HI) begin
        rxs_hi_r <= reg_wdata & MASK_HI;
      end else if (reg_addr == OFS_GAIN) begin
        gain_r <= reg_wdata & MASK_GAIN;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  assign rdata_nxt = (reg_addr == OFS_MODE) ? mode_r :
                     (reg_addr == OFS_TXS_LO) ? txs_lo_r :
                     (reg_addr == OFS_TXS_HI) ? txs_hi_r :
                     (reg_addr == OFS_RXS_LO) ? rxs_lo_r :
                     (reg_addr == OFS_RXS_HI) ? rxs_hi_r :
                     (reg_addr == OFS_GAIN) ? gain_r :
                     (reg_addr == OFS_RXD_LO) ? rxd_r[7:0] :
                     (reg_addr == OFS_RXD_HI) ? rxd_r[15:8] : 8'h00;

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  // Analog-side controls registered out
  always_ff @(posedge clk) begin
    if (rst) begin
      analog_loopback <= 1'b0;
      coarse_tx_direction <= 1'b0;
      coarse_tx_db <= 4'h0;
    end else begin
      analog_loopback <= cfg.loopback;
      coarse_tx_direction <= gain.atten;
      coarse_tx_db <= gain.db;
    end
  end

  // Two-flop synchronisers for the highway pins
  logic [1:0] clk_s1_r, fs_s_r, rx_s_r;
  logic clk_d_r, fs_d_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_s1_r <= 2'h0;
      fs_s_r <= 2'h0;
      rx_s_r <= 2'h0;
      clk_d_r <= 1'b0;
      fs_d_r <= 1'b0;
    end else begin
      clk_s1_r <= {clk_s1_r[0], bit_clk};
      fs_s_r <= {fs_s_r[0], frame_sync};
      rx_s_r <= {rx_s_r[0], hwy_rx};
      clk_d_r <= clk_s1_r[1];
      fs_d_r <= fs_s_r[1];
    end
  end
  // Edge detection on the second stage only
  wire bclk_rise = clk_s1_r[1] && !clk_d_r;
  wire bclk_fall = !clk_s1_r[1] && clk_d_r;
  wire fs_rise = fs_s_r[1] && !fs_d_r;

  // Sample width from format: companded and 8-bit linear are 8 bits
  wire [4:0] samp_len = (cfg.fmt == FMT_LIN16) ? LEN_16 : LEN_8;

  // Transmit FIFO between codec path and highway
  logic [15:0] fifo_data;
  logic fifo_valid, fifo_pop;
  sample_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(tx_sample),
    .in_valid(tx_sample_valid),
    .in_ready(tx_sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Format the outgoing word, left-justified in 16 bits
  function automatic logic [15:0] fmt_word(input logic [1:0] f, input logic [15:0] s);
    logic [15:0] r;
    r = s;
    if (f == FMT_LIN8) begin
      r = {s[15:8], 8'h00};
    end else if (f == FMT_ALAW || f == FMT_ULAW) begin
      // Companding tables sit outside; the low byte carries the coded sample
      r = {s[7:0], 8'h00};
    end
    return r;
  endfunction

  // Bit-clock counter since frame sync, and sub-clock phase for two-clock bits
  logic [10:0] bcnt_r;
  logic [4:0] tx_left_r, rx_left_r;
  logic tx_ph_r, rx_ph_r, tx_act_r, rx_act_r, rel_pend_r;
  logic [15:0] tx_sh_r, rx_sh_r;
  wire [10:0] txs_ext = {1'b0, cfg.tx_start_count};
  wire [10:0] rxs_ext = {1'b0, cfg.rx_start_count};
  wire tx_start = cfg.enable && bclk_rise && (bcnt_r == txs_ext) && !tx_act_r;
  // Arm on the fall that closes clock rxs, so the first (MSB) bit is caught in clock rxs+1, or rxs+2 with two-clock bits
  wire rx_start = cfg.enable && bclk_fall && (bcnt_r == rxs_ext) && !rx_act_r;
  assign fifo_pop = tx_start && fifo_valid;
  // An empty buffer sends zeros rather than a stale word
  wire [15:0] tx_word = fifo_valid ? fmt_word(cfg.fmt, fifo_data) : 16'h0000;
  // Final bit clock of bit 0 is under way
  wire tx_last_half = (tx_left_r == 5'h0) && (!cfg.two_clk || tx_ph_r);
  // Bit step: every clock, or every second clock
  wire tx_step = bclk_rise && (!cfg.two_clk || tx_ph_r);
  wire rx_step = bclk_fall && (!cfg.two_clk || rx_ph_r);
  wire rel_edge = cfg.rel_fall ? bclk_fall : bclk_rise;

  // Bit counter: reset on frame sync, counts rising bit clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      bcnt_r <= 11'h0;
    end else if (fs_rise) begin
      bcnt_r <= 11'h0;
    end else if (bclk_rise && bcnt_r != 11'h7ff) begin
      bcnt_r <= bcnt_r + 11'h1;
    end
  end

  // Transmit shifter, MSB first; release after bit 0 on chosen edge
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_act_r <= 1'b0;
      tx_ph_r <= 1'b0;
      tx_left_r <= 5'h0;
      tx_sh_r <= 16'h0;
      rel_pend_r <= 1'b0;
      hwy_tx <= 1'b0;
      hwy_tx_oe <= 1'b0;
    end else if (!cfg.enable) begin
      tx_act_r <= 1'b0;
      rel_pend_r <= 1'b0;
      hwy_tx_oe <= 1'b0;
    end else if (tx_start) begin
      tx_act_r <= 1'b1;
      tx_ph_r <= 1'b0;
      tx_left_r <= samp_len - 5'h1;
      tx_sh_r <= {tx_word[14:0], 1'b0};
      hwy_tx <= tx_word[15];
      hwy_tx_oe <= 1'b1;
    end else if (tx_act_r) begin
      if (bclk_rise && cfg.two_clk) begin
        tx_ph_r <= !tx_ph_r;
      end
      if (tx_step) begin
        if (tx_left_r == 5'h0) begin
          tx_act_r <= 1'b0;
          rel_pend_r <= 1'b1;
        end else begin
          hwy_tx <= tx_sh_r[15];
          tx_sh_r <= {tx_sh_r[14:0], 1'b0};
          tx_left_r <= tx_left_r - 5'h1;
        end
      end
      // Falling-edge release: let go once the master has sampled bit 0
      if (cfg.rel_fall && bclk_fall && tx_last_half) begin
        tx_act_r <= 1'b0;
        hwy_tx_oe <= 1'b0;
      end
    end else if (rel_pend_r && (rel_edge || cfg.rel_fall == 1'b0)) begin
      rel_pend_r <= 1'b0;
      hwy_tx_oe <= 1'b0;
    end
  end

  // Receive shifter, samples on falling bit clock
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_act_r <= 1'b0;
      rx_ph_r <= 1'b0;
      rx_left_r <= 5'h0;
      rx_sh_r <= 16'h0;
      rxd_r <= 16'h0;
      rx_sample <= 16'h0;
      rx_sample_valid <= 1'b0;
    end else begin
      rx_sample_valid <= 1'b0;
      if (!cfg.enable) begin
        rx_act_r <= 1'b0;
      end else if (rx_start) begin
        rx_act_r <= 1'b1;
        rx_ph_r <= cfg.two_clk ? 1'b0 : 1'b1;
        rx_left_r <= samp_len;
        rx_sh_r <= 16'h0000;
      end else if (rx_act_r) begin
        if (bclk_fall && cfg.two_clk) begin
          rx_ph_r <= !rx_ph_r;
        end
        if (rx_step) begin
          rx_sh_r <= {rx_sh_r[14:0], rx_s_r[1]};
          rx_left_r <= rx_left_r - 5'h1;
          if (rx_left_r == 5'h1) begin
            rx_act_r <= 1'b0;
            rx_sample_valid <= 1'b1;
            rxd_r <= {rx_sh_r[14:0], rx_s_r[1]};
            rx_sample <= {rx_sh_r[14:0], rx_s_r[1]};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/hwy_sva.sv ***
// Port assertions for the highway block
`timescale 1ns/1ps
`default_nettype none
module hwy_sva import hwy_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic analog_loopback,
  input wire logic coarse_tx_direction,
  input wire logic [3:0] coarse_tx_db,
  input wire logic rx_sample_valid,
  input wire logic hwy_tx_oe
);
  logic [7:0] mode_r; // Shadow of the mode register
  logic [7:0] gain_r; // Shadow of the gain register
  wire logic [3:0] db_exp; // Codes 11xx saturate only in gain
  assign db_exp = (!gain_r[BIT_DIR] && &gain_r[3:2]) ? GAIN_MAX_DB : gain_r[3:0];
  // Follow writes as software issued them
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= RST_REG;
      gain_r <= RST_REG;
    end else if (reg_wr && reg_addr == OFS_MODE) begin
      mode_r <= reg_wdata;
    end else if (reg_wr && reg_addr == OFS_GAIN) begin
      gain_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Outputs are judged only once their register has been quiet a while
  sequence gain_quiet;
    $stable(gain_r) [*3];
  endsequence
  sequence mode_quiet;
    $stable(mode_r) [*3];
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_mode_read: assert property (
    reg_rd && reg_addr == OFS_MODE |=> reg_rdata == (mode_r & MASK_MODE))
    else $error("mode readback");
  a_gain_read: assert property (
    reg_rd && reg_addr == OFS_GAIN |=> reg_rdata == (gain_r & MASK_GAIN))
    else $error("gain readback");
  a_gain_step: assert property (gain_quiet |-> coarse_tx_db == db_exp)
    else $error("gain step");
  a_gain_dir: assert property (gain_quiet |-> coarse_tx_direction == gain_r[BIT_DIR])
    else $error("gain direction");
  a_loop_follow: assert property (mode_quiet |-> analog_loopback == mode_r[BIT_LOOP])
    else $error("loopback");
  a_oe_disabled: assert property (!mode_r[BIT_EN] [*3] |=> !hwy_tx_oe)
    else $error("driving while disabled");
  a_rx_pulse: assert property (rx_sample_valid |=> !rx_sample_valid)
    else $error("rx valid too long");
endmodule
`default_nettype wire

// *** tb/hwy_master.sv ***
// Behavioural highway master: bit clock, frame sync, receive data
`timescale 1ns/1ps
`default_nettype none
module hwy_master (
  output logic bit_clk,
  output logic frame_sync,
  output logic hwy_rx,
  input wire logic hwy_tx,
  input wire logic hwy_tx_oe
);
  logic [31:0] cap; // Driven bits, newest last
  int ncap; // Clocks seen with output driven
  int first; // Clock index of first driven bit
  realtime t_last, t_rel; // Last driven sample, release moment
  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b0;
    hwy_rx = 1'b0;
  end
  always @(negedge hwy_tx_oe) t_rel = $realtime;
  // One frame; clock stands low between frames
  task automatic frame(input int rx_start_count, input logic [15:0] w, input int nb, m, nr);
    int j;
    ncap = 0;
    cap = 32'h0;
    first = -1;
    #1.3 frame_sync = 1'b1;
    for (int k = 1; k <= nr; k++) begin
      #40 bit_clk = 1'b1;
      frame_sync = 1'b0;
      j = (k - rx_start_count - 1) / m;
      // Idle clocks toggle the line so stale data never passes
      hwy_rx = (k > rx_start_count && j < nb) ? w[nb - 1 - j] : !hwy_rx;
      #40 bit_clk = 1'b0;
      if (hwy_tx_oe === 1'b1) begin
        if (first < 0) first = k;
        cap = {cap[30:0], hwy_tx};
        ncap++;
        t_last = $realtime;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the highway block
`timescale 1ns/1ps
`default_nettype none
module tb import hwy_pkg::*; ;
  localparam int FIFO_D = 16; // Buffer depth
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tx_sample_valid = 1'b0;
  logic [15:0] tx_sample = 16'h0000, rx_sample, rx_got;
  logic [3:0] coarse_tx_db;
  logic tx_sample_ready, analog_loopback, coarse_tx_direction, rx_sample_valid, rx_seen;
  logic bit_clk, frame_sync, hwy_rx, hwy_tx, hwy_tx_oe;
  logic [15:0] txq[$]; // Words in the buffer, oldest first
  int n_fail = 0, samples_checked = 0, cyc = 0;
  pcm_highway_config #(.FIFO_DEPTH(FIFO_D)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_sample(tx_sample), .tx_sample_valid(tx_sample_valid), .tx_sample_ready(tx_sample_ready),
    .analog_loopback(analog_loopback), .coarse_tx_direction(coarse_tx_direction),
    .coarse_tx_db(coarse_tx_db), .rx_sample(rx_sample), .rx_sample_valid(rx_sample_valid),
    .bit_clk(bit_clk), .frame_sync(frame_sync), .hwy_rx(hwy_rx), .hwy_tx(hwy_tx),
    .hwy_tx_oe(hwy_tx_oe));
  hwy_master hm (.bit_clk(bit_clk), .frame_sync(frame_sync), .hwy_rx(hwy_rx), .hwy_tx(hwy_tx),
    .hwy_tx_oe(hwy_tx_oe));
  initial forever #2.5 clk = ~clk;
  // Catch samples handed up; cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (rx_sample_valid === 1'b1) begin
      rx_got <= rx_sample;
      rx_seen <= 1'b1;
    end
    if (cyc == 60000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic give_verdict();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset values, writable bits, unmapped read
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] ofs[6] = '{OFS_MODE, OFS_TXS_LO, OFS_TXS_HI, OFS_RXS_LO, OFS_RXS_HI, OFS_GAIN};
    logic [7:0] msk[6] = '{MASK_MODE, 8'hff, MASK_HI, 8'hff, MASK_HI, MASK_GAIN};
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], d);
      check(d, RST_REG);
      wr(ofs[i], 8'hdb); // Enable and bit 2 stay clear
      rd(ofs[i], d);
      check(d, 8'hdb & msk[i]);
      wr(ofs[i], 8'h00);
    end
    rd(8'h20, d);
    check(d, 8'h00);
    $display("regs done");
  endtask
  // Every step code in both directions, then loopback
  task automatic t_gain();
    logic [4:0] g;
    logic [3:0] e;
    for (int i = 0; i < 32; i++) begin
      g = i[4:0];
      e = (!g[4] && &g[3:2]) ? 4'hc : g[3:0];
      wr(OFS_GAIN, {3'h0, g});
      repeat (3) @(posedge clk);
      #1;
      check({coarse_tx_direction, coarse_tx_db}, {g[4], e});
    end
    wr(OFS_MODE, 8'h80);
    repeat (3) @(posedge clk);
    #1;
    check(analog_loopback, 1'b1);
    wr(OFS_MODE, 8'h00);
    $display("gain done");
  endtask
  // Fill the buffer until it refuses
  task automatic t_fifo();
    int n;
    @(posedge clk);
    for (n = 0; n < 20; n++) begin
      tx_sample <= 16'h9a30 + 16'h0111 * n[15:0];
      tx_sample_valid <= 1'b1;
      #4;
      if (tx_sample_ready !== 1'b1) break;
      txq.push_back(16'h9a30 + 16'h0111 * n[15:0]);
      @(posedge clk);
    end
    @(posedge clk);
    tx_sample_valid <= 1'b0;
    check(32'(n), 32'(FIFO_D));
    $display("fifo done");
  endtask
  // One frame: program, run, compare both directions
  task automatic t_frame(input logic [1:0] f, input logic two, rel, en, input logic [9:0] tx_start_count, rx_start_count);
    logic [15:0] w, s, rw;
    logic [31:0] e;
    logic [7:0] d;
    int nb, m;
    nb = (f == FMT_LIN16) ? 16 : 8;
    m = two ? 2 : 1;
    rw = 16'hc5a3 ^ {6'h00, tx_start_count};
    w = (en && txq.size() > 0) ? txq.pop_front() : 16'h0000; // Empty buffer sends zeros
    s = (f == FMT_LIN16) ? w : (f == FMT_LIN8) ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    e = 32'h0;
    for (int i = nb - 1; i >= 0; i--) begin
      repeat (m) e = {e[30:0], s[i]};
    end
    wr(OFS_MODE, 8'h00);
    wr(OFS_TXS_LO, tx_start_count[7:0]);
    wr(OFS_TXS_HI, {6'h00, tx_start_count[9:8]});
    wr(OFS_RXS_LO, rx_start_count[7:0]);
    wr(OFS_RXS_HI, {6'h00, rx_start_count[9:8]});
    wr(OFS_MODE, {2'h0, en, f, 1'b0, two, rel});
    rx_seen = 1'b0;
    hm.frame(rx_start_count, rw, nb, m, (tx_start_count > rx_start_count ? tx_start_count : rx_start_count) + nb * m + 4);
    repeat (8) @(posedge clk);
    #1;
    check(hm.ncap, en ? nb * m : 0);
    check(rx_seen, en);
    if (en) begin
      check(hm.cap, e);
      check(hm.first == tx_start_count || hm.first == tx_start_count + 1, 1'b1);
      check(rx_got, nb == 16 ? rw : {8'h00, rw[7:0]});
      rd(OFS_RXD_LO, d);
      check(d, rw[7:0]);
      rd(OFS_RXD_HI, d);
      check(d, nb == 16 ? rw[15:8] : 8'h00);
      check(hm.t_rel - hm.t_last > 40.0, !rel);
    end
    $display("frame done fmt %0d", f);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_gain();
    t_fifo();
    for (int f = 0; f < 4; f++) begin
      t_frame(f[1:0], f[0], f[1], 1'b1, 10'(3 + f), 10'(5 - f));
    end
    t_frame(FMT_LIN16, 1'b0, 1'b0, 1'b1, 10'h3ff, 10'h3fe);
    while (txq.size() > 0) t_frame(FMT_ULAW, 1'b1, 1'b1, 1'b1, 10'h001, 10'h001);
    check(tx_sample_ready, 1'b1);
    t_frame(FMT_ALAW, 1'b0, 1'b0, 1'b1, 10'h002, 10'h001);
    t_frame(FMT_LIN16, 1'b0, 1'b0, 1'b0, 10'h002, 10'h001);
    give_verdict();
  end
endmodule
bind pcm_highway_config hwy_sva chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .analog_loopback(analog_loopback), .coarse_tx_direction(coarse_tx_direction),
  .coarse_tx_db(coarse_tx_db), .rx_sample_valid(rx_sample_valid), .hwy_tx_oe(hwy_tx_oe));
`default_nettype wire
